// ===== flash_link_cfg.svh
// Constants shared by both ends of the serial flash read link.
// Assumes both ends run from one 250 MHz clock; included by bare name.
`ifndef FLASH_LINK_CFG_SVH
`define FLASH_LINK_CFG_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define OP_BUF1_FAST   8'hD4
`define OP_BUF1_SLOW   8'hD1
`define OP_BUF2_FAST   8'hD6
`define OP_BUF2_SLOW   8'hD3
`define OP_DUAL_READ   8'h3B
`define OP_QUAD_READ   8'h6B

// ----------------------------------------------------------------
// Field layout and sizes
// ----------------------------------------------------------------
`define OP_BITS        8
`define ADDR_BITS      24
`define DUMMY_BITS     8
`define BYTE_BITS      10
`define PAGE_BITS      13
`define LINEAR_BITS    22
`define IDX_528_BITS   10
`define IDX_512_BITS   9
`define SIZE_528       10'd528
`define SIZE_512       10'd512

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MCLK_PERIOD_NS 4
`define SCK_PERIOD_NS  48
`define SCK_HALF_CYC   ((`SCK_PERIOD_NS / 2 + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`endif

// ===== flash_link_if.sv
// Pins between the host controller and the flash read sequencer.
// Lane 0 is the serial input, lane 1 the serial output; undriven
// lanes resolve high as if pulled up.
`timescale 1ns/1ps

interface flash_link_if;
	logic       cs_n;
	logic       sck;
	logic [3:0] host_io;
	logic [3:0] host_oe_n;
	logic [3:0] dev_io;
	logic [3:0] dev_oe_n;
	logic [3:0] io;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (!dev_oe_n[i])
				io[i] = dev_io[i];
			else if (!host_oe_n[i])
				io[i] = host_io[i];
			else
				io[i] = 1'b1;
		end
	end

	modport host (output cs_n, output sck, output host_io,
		output host_oe_n, input io);
	modport dev (input cs_n, input sck, input io, output dev_io,
		output dev_oe_n);
endinterface : flash_link_if

// ===== flash_link_pkg.sv
// Types and opcode decoding shared by both ends of the flash read link.
// Assumes flash_link_cfg.svh is on the include path.
`include "flash_link_cfg.svh"

package flash_link_pkg;

	typedef enum logic [1:0] {SRC_ARRAY, SRC_BUF1, SRC_BUF2} mem_src_t;
	typedef enum {DS_IDLE, DS_ADDR, DS_DUMMY, DS_DATA, DS_IGNORE} dev_st_t;
	typedef enum {HS_IDLE, HS_CMD, HS_READ, HS_END, HS_GAP} host_st_t;
	typedef logic [3:0] lanes_t;

	// Lanes per clock of the data phase; zero marks an opcode not honoured.
	function automatic lanes_t op_lanes(input logic [7:0] op,
		input logic quad_en);
		case (op)
		`OP_BUF1_FAST, `OP_BUF1_SLOW,
		`OP_BUF2_FAST, `OP_BUF2_SLOW: op_lanes = 4'd1;
		`OP_DUAL_READ: op_lanes = 4'd2;
		`OP_QUAD_READ: op_lanes = quad_en ? 4'd4 : 4'd0;
		default: op_lanes = 4'd0;
		endcase
	endfunction : op_lanes

	function automatic logic op_dummy(input logic [7:0] op);
		op_dummy = (op == `OP_BUF1_FAST) || (op == `OP_BUF2_FAST) ||
			(op == `OP_DUAL_READ) || (op == `OP_QUAD_READ);
	endfunction : op_dummy

endpackage : flash_link_pkg

// ===== flash_link_sva.sv
// Pin checker for the flash read link between host and device.
// Assumes it sits beside the link interface, in the mclk_i domain.
`timescale 1ns/1ps
`include "flash_link_cfg.svh"

module flash_link_sva (
	input wire logic       mclk_i,
	input wire logic       rst_i,
	input wire logic       cs_n,
	input wire logic       sck,
	input wire logic [3:0] host_io,
	input wire logic [3:0] host_oe_n,
	input wire logic [3:0] dev_io,
	input wire logic [3:0] dev_oe_n,
	input wire logic [3:0] io
);
	logic [15:0] rise_q;
	logic [15:0] need;
	logic [7:0]  op_q;
	logic [3:0]  hi_q;
	logic        sck_q;

	// ----
	// Helpers
	// ----
	// Slow buffer reads skip the dummy byte, so data follows 32 rises.
	assign need = (op_q == `OP_BUF1_SLOW || op_q == `OP_BUF2_SLOW) ?
		16'h0020 : 16'h0028;
	always_ff @(posedge mclk_i) begin
		sck_q <= sck;
		if (rst_i || cs_n) begin
			rise_q <= 16'h0000;
			op_q   <= 8'h00;
		end else if (sck && !sck_q) begin
			rise_q <= rise_q + 16'h0001;
			if (rise_q < 16'h0008)
				op_q <= {op_q[6:0], io[0]};
		end
		if (rst_i || !cs_n)
			hi_q <= 4'h0;
		else if (hi_q != 4'hF)
			hi_q <= hi_q + 4'h1;
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	sequence released_s;
		##[0:6] (dev_oe_n == 4'hF);
	endsequence
	sequence sck_high_s;
		sck [*6] ##1 !sck;
	endsequence

	// ----
	// Properties
	// ----
	cs_release_a:
	assert property ($rose(cs_n) |-> released_s)
		else $error("lanes still driven after chip select rose");
	idle_quiet_a:
	assert property ((hi_q == 4'hF) |-> (dev_oe_n == 4'hF))
		else $error("lanes driven while deselected");
	drive_start_a:
	assert property ($fell(dev_oe_n == 4'hF) |-> (rise_q == need))
		else $error("data phase began at the wrong clock");
	lane_shape_a:
	assert property (dev_oe_n inside {4'hF, 4'hD, 4'hC, 4'h0})
		else $error("device drove an odd set of lanes");
	no_clash_a:
	assert property ((~dev_oe_n & ~host_oe_n) == 4'h0)
		else $error("both ends drove one lane");
	host_lane_a:
	assert property (host_oe_n[3:1] == 3'b111)
		else $error("host drove a lane other than lane 0");
	sck_phase_a:
	assert property ($rose(sck) |-> sck_high_s)
		else $error("clock high phase not six cycles");
	dev_hold_a:
	assert property ((sck && $past(sck) && dev_oe_n != 4'hF &&
		$past(dev_oe_n) == dev_oe_n) |-> $stable(dev_io & ~dev_oe_n))
		else $error("device data moved while clock high");
	host_hold_a:
	assert property ((sck && $past(sck) && !host_oe_n[0] &&
		!$past(host_oe_n[0])) |-> $stable(host_io[0]))
		else $error("host data moved while clock high");
	cs_sck_a:
	assert property (cs_n |-> !sck)
		else $error("clock high while deselected");
endmodule : flash_link_sva

// ===== flash_read_dev.sv
// Flash side of the read link: buffer reads and two/four-lane array reads.
// Assumes memory answers mem_data_i one clock after mem_addr_o changes.
`timescale 1ns/1ps
`include "flash_link_cfg.svh"

module flash_read_dev (
	input  wire logic                 mclk_i,
	input  wire logic                 rst_i,
	input  wire logic                 ce_i,
	input  wire logic                 page_512_i,
	input  wire logic                 four_lane_en_i,
	output flash_link_pkg::mem_src_t  mem_sel_o,
	output logic [22:0]               mem_addr_o,
	input  wire logic [7:0]           mem_data_i,
	output logic                      active_o,
	flash_link_if.dev                 link
);
	import flash_link_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] cs_q, sck_q, si_q;
	logic       sck_rise, sck_fall;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			cs_q  <= 3'b111;
			sck_q <= 3'b000;
			si_q  <= 3'b000;
		end else if (ce_i) begin
			cs_q  <= {cs_q[1:0], link.cs_n};
			sck_q <= {sck_q[1:0], link.sck};
			si_q  <= {si_q[1:0], link.io[0]};
		end
	end

	assign sck_rise = sck_q[1] && !sck_q[2];
	assign sck_fall = !sck_q[1] && sck_q[2];

	// ----------------------------------------------------------------
	// Address stepping
	// ----------------------------------------------------------------
	// Buffers wrap inside themselves; the array carries byte into page
	// and lets the page index roll over, so no boundary costs a clock.
	function automatic logic [22:0] next_addr(input logic [22:0] a,
		input mem_src_t src, input logic p512);
		logic [9:0] size;
		size = p512 ? `SIZE_512 : `SIZE_528;
		next_addr = a + 23'h00_0001;
		if (src != SRC_ARRAY) begin
			if (a[9:0] == size - 10'h001)
				next_addr = 23'h00_0000;
		end else if (p512) begin
			next_addr = {1'b0, a[21:0] + 22'h00_0001};
		end else if (a[9:0] == size - 10'h001) begin
			next_addr = {a[22:10] + 13'h0001, 10'h000};
		end
	endfunction : next_addr

	// Maps the received address word onto the memory port layout.
	function automatic logic [22:0] start_addr(input logic [23:0] w,
		input mem_src_t src, input logic p512);
		if (src == SRC_ARRAY)
			start_addr = p512 ? {1'b0, w[21:0]} : w[22:0];
		else if (p512)
			start_addr = {14'h0000, w[8:0]};
		else
			start_addr = {13'h0000, w[9:0]};
	endfunction : start_addr

	// ----------------------------------------------------------------
	// Command sequencer
	// ----------------------------------------------------------------
	dev_st_t     st_q, st_d;
	logic [4:0]  cnt_q, cnt_d;
	logic [23:0] sr_q, sr_d;
	logic [22:0] addr_q, addr_d;
	mem_src_t    src_q, src_d;
	lanes_t      lanes_q, lanes_d;
	logic        dummy_q, dummy_d;
	logic [3:0]  pos_q, pos_d;
	logic [7:0]  sh_q, sh_d;
	logic [7:0]  nxt_q;
	logic [3:0]  oe_n_q, oe_n_d;
	logic [23:0] sr_in;
	logic [7:0]  op_in;

	assign sr_in = {sr_q[22:0], si_q[2]};
	assign op_in = sr_in[7:0];

	always_comb begin
		st_d    = st_q;
		cnt_d   = cnt_q;
		sr_d    = sr_q;
		addr_d  = addr_q;
		src_d   = src_q;
		lanes_d = lanes_q;
		dummy_d = dummy_q;
		pos_d   = pos_q;
		sh_d    = sh_q;
		oe_n_d  = oe_n_q;
		if (cs_q[2]) begin
			st_d   = DS_IDLE;
			cnt_d  = 5'd0;
			pos_d  = 4'd0;
			oe_n_d = 4'b1111;
		end else if (sck_rise) begin
			case (st_q)
			DS_IDLE: begin
				sr_d  = sr_in;
				cnt_d = cnt_q + 5'd1;
				if (cnt_q == 5'(`OP_BITS - 1)) begin
					cnt_d   = 5'd0;
					lanes_d = op_lanes(op_in, four_lane_en_i);
					dummy_d = op_dummy(op_in);
					case (op_in)
					`OP_BUF1_FAST, `OP_BUF1_SLOW: src_d = SRC_BUF1;
					`OP_BUF2_FAST, `OP_BUF2_SLOW: src_d = SRC_BUF2;
					default: src_d = SRC_ARRAY;
					endcase
					st_d = (op_lanes(op_in, four_lane_en_i) == 4'd0) ?
						DS_IGNORE : DS_ADDR;
				end
			end
			DS_ADDR: begin
				sr_d  = sr_in;
				cnt_d = cnt_q + 5'd1;
				if (cnt_q == 5'(`ADDR_BITS - 1)) begin
					cnt_d  = 5'd0;
					addr_d = start_addr(sr_in, src_q, page_512_i);
					st_d   = dummy_q ? DS_DUMMY : DS_DATA;
				end
			end
			DS_DUMMY: begin
				cnt_d = cnt_q + 5'd1;
				if (cnt_q == 5'(`DUMMY_BITS - 1)) begin
					cnt_d = 5'd0;
					st_d  = DS_DATA;
				end
			end
			default: ;
			endcase
		end else if (sck_fall && st_q == DS_DATA) begin
			case (lanes_q)
			4'd4:    oe_n_d = 4'b0000;
			4'd2:    oe_n_d = 4'b1100;
			default: oe_n_d = 4'b1101;
			endcase
			if (pos_q == 4'd0) begin
				sh_d   = nxt_q;
				addr_d = next_addr(addr_q, src_q, page_512_i);
				pos_d  = 4'd8 - lanes_q;
			end else begin
				sh_d  = sh_q << lanes_q;
				pos_d = pos_q - lanes_q;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st_q    <= DS_IDLE;
			cnt_q   <= 5'd0;
			sr_q    <= 24'h00_0000;
			addr_q  <= 23'h00_0000;
			src_q   <= SRC_ARRAY;
			lanes_q <= 4'd1;
			dummy_q <= 1'b0;
			pos_q   <= 4'd0;
			sh_q    <= 8'h00;
			nxt_q   <= 8'h00;
			oe_n_q  <= 4'b1111;
		end else if (ce_i) begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			sr_q    <= sr_d;
			addr_q  <= addr_d;
			src_q   <= src_d;
			lanes_q <= lanes_d;
			dummy_q <= dummy_d;
			pos_q   <= pos_d;
			sh_q    <= sh_d;
			nxt_q   <= mem_data_i;
			oe_n_q  <= oe_n_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// The memory port is read only, so no read can alter a buffer.
	assign mem_sel_o   = src_q;
	assign mem_addr_o  = addr_q;
	assign active_o    = (st_q != DS_IDLE) && (st_q != DS_IGNORE);
	assign link.dev_oe_n = oe_n_q;
	assign link.dev_io = (lanes_q == 4'd4) ? sh_q[7:4] :
		{2'b00, sh_q[7], sh_q[6]};

endmodule : flash_read_dev

// ===== flash_read_host.sv
// Host controller end of the flash read link: issues one read, collects
// bytes into a small buffer. Assumes flash_read_dev on the far side.
`timescale 1ns/1ps
`include "flash_link_cfg.svh"

module flash_read_host #(
	parameter int unsigned SCK_HALF = `SCK_HALF_CYC,
	parameter int unsigned DEPTH    = 2
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        cmd_valid_i,
	output logic             cmd_ready_o,
	input  wire logic [7:0]  cmd_op_i,
	input  wire logic [23:0] cmd_addr_i,
	input  wire logic [15:0] cmd_len_i,
	output logic             rd_valid_o,
	output logic [7:0]       rd_data_o,
	input  wire logic        rd_ready_i,
	output logic             busy_o,
	flash_link_if.host       link
);
	import flash_link_pkg::*;

	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	host_st_t    st_q, st_d;
	logic [7:0]  div_q, div_d;
	logic        cs_n_q, cs_n_d, sck_q, sck_d;
	logic [39:0] tx_q, tx_d;
	logic [5:0]  bits_q, bits_d, nbits_q, nbits_d;
	lanes_t      lanes_q, lanes_d;
	logic [3:0]  rxc_q, rxc_d;
	logic [7:0]  rx_q, rx_d;
	logic [15:0] left_q, left_d;
	logic        oe_q, oe_d;
	logic [3:0]  io_s1, io_s2;
	logic        tick, full, push, pop;
	logic [7:0]  rx_n;

	assign tick = (div_q == 8'(SCK_HALF - 1));

	always_comb begin
		case (lanes_q)
		4'd4:    rx_n = {rx_q[3:0], io_s2};
		4'd2:    rx_n = {rx_q[5:0], io_s2[1], io_s2[0]};
		default: rx_n = {rx_q[6:0], io_s2[1]};
		endcase
	end

	always_comb begin
		st_d    = st_q;
		div_d   = tick ? 8'd0 : div_q + 8'd1;
		cs_n_d  = cs_n_q;
		sck_d   = sck_q;
		tx_d    = tx_q;
		bits_d  = bits_q;
		nbits_d = nbits_q;
		lanes_d = lanes_q;
		rxc_d   = rxc_q;
		rx_d    = rx_q;
		left_d  = left_q;
		oe_d    = oe_q;
		push    = 1'b0;
		case (st_q)
		HS_IDLE: begin
			if (cmd_valid_i) begin
				div_d   = 8'd0;
				cs_n_d  = 1'b0;
				oe_d    = 1'b1;
				tx_d    = {cmd_op_i, cmd_addr_i, 8'h00};
				nbits_d = op_dummy(cmd_op_i) ? 6'd40 : 6'd32;
				lanes_d = op_lanes(cmd_op_i, 1'b1);
				left_d  = cmd_len_i;
				bits_d  = 6'd0;
				rxc_d   = 4'd0;
				st_d    = HS_CMD;
			end
		end
		HS_CMD: begin
			if (tick && !sck_q) begin
				sck_d = 1'b1;
			end else if (tick) begin
				sck_d  = 1'b0;
				tx_d   = tx_q << 1;
				bits_d = bits_q + 6'd1;
				if (bits_q == nbits_q - 6'd1) begin
					oe_d = 1'b0;
					st_d = HS_READ;
				end
			end
		end
		HS_READ: begin
			// A byte is only started when the buffer has room for it.
			if (tick && !sck_q) begin
				if (!(rxc_q == 4'd0 && full))
					sck_d = 1'b1;
			end else if (tick) begin
				sck_d = 1'b0;
				rx_d  = rx_n;
				rxc_d = rxc_q + lanes_q;
				if (rxc_q + lanes_q == 4'd8) begin
					push   = 1'b1;
					rxc_d  = 4'd0;
					left_d = left_q - 16'd1;
					if (left_q <= 16'd1)
						st_d = HS_END;
				end
			end
		end
		HS_END: begin
			if (tick) begin
				cs_n_d = 1'b1;
				st_d   = HS_GAP;
			end
		end
		default: begin
			if (tick)
				st_d = HS_IDLE;
		end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st_q    <= HS_IDLE;
			div_q   <= 8'd0;
			cs_n_q  <= 1'b1;
			sck_q   <= 1'b0;
			tx_q    <= 40'h00_0000_0000;
			bits_q  <= 6'd0;
			nbits_q <= 6'd32;
			lanes_q <= 4'd1;
			rxc_q   <= 4'd0;
			rx_q    <= 8'h00;
			left_q  <= 16'h0000;
			oe_q    <= 1'b0;
			io_s1   <= 4'h0;
			io_s2   <= 4'h0;
		end else if (ce_i) begin
			st_q    <= st_d;
			div_q   <= div_d;
			cs_n_q  <= cs_n_d;
			sck_q   <= sck_d;
			tx_q    <= tx_d;
			bits_q  <= bits_d;
			nbits_q <= nbits_d;
			lanes_q <= lanes_d;
			rxc_q   <= rxc_d;
			rx_q    <= rx_d;
			left_q  <= left_d;
			oe_q    <= oe_d;
			io_s1   <= link.io;
			io_s2   <= io_s1;
		end
	end

	// ----------------------------------------------------------------
	// Receive buffer
	// ----------------------------------------------------------------
	logic [7:0]    mem_q [DEPTH];
	logic [7:0]    mem_d [DEPTH];
	logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [PW:0]   cnt_q, cnt_d;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : bump

	assign full = (cnt_q == (PW+1)'(DEPTH));
	assign pop  = rd_valid_o && rd_ready_i;

	always_comb begin
		mem_d = mem_q;
		wp_d  = wp_q;
		rp_d  = rp_q;
		cnt_d = cnt_q;
		if (push) begin
			mem_d[wp_q] = rx_n;
			wp_d = bump(wp_q);
		end
		if (pop)
			rp_d = bump(rp_q);
		if (push && !pop)
			cnt_d = cnt_q + 1'b1;
		else if (pop && !push)
			cnt_d = cnt_q - 1'b1;
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			for (int i = 0; i < DEPTH; i++)
				mem_q[i] <= 8'h00;
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else if (ce_i) begin
			mem_q <= mem_d;
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign rd_valid_o     = (cnt_q != '0);
	assign rd_data_o      = mem_q[rp_q];
	assign cmd_ready_o    = (st_q == HS_IDLE);
	assign busy_o         = (st_q != HS_IDLE);
	assign link.cs_n      = cs_n_q;
	assign link.sck       = sck_q;
	assign link.host_io   = {3'b000, tx_q[39]};
	assign link.host_oe_n = {3'b111, !oe_q};

endmodule : flash_read_host

// ===== serial_flash_buffer_and_multi_lane_read_tb.sv
// Bench joining the read host and the read device over the link.
// Assumes the header, package, interface and both ends compile first.
`timescale 1ns/1ps
`include "flash_link_cfg.svh"

module serial_flash_buffer_and_multi_lane_read_tb;
	import flash_link_pkg::*;

	typedef struct {
		logic [7:0]  op;
		logic [23:0] addr;
		logic [15:0] len;
		logic        p512;
		logic        quad_en;
		logic [7:0]  first;
	} row_t;

	logic        mclk_i  = 1'b0;
	logic        rst_i   = 1'b1;
	logic        ce      = 1'b1;
	logic        p512    = 1'b0;
	logic        quad_en = 1'b0;
	logic        valid   = 1'b0;
	logic        rdy     = 1'b1;
	logic [7:0]  op      = 8'h00;
	logic [23:0] addr    = 24'h00_0000;
	logic [15:0] len     = 16'h0001;
	logic [7:0]  mdata   = 8'h00;
	logic [7:0]  w_op    = 8'h00;
	logic [3:0]  w_first = 4'h0;
	logic        sck_q   = 1'b0;
	logic        cmd_rdy, rd_valid, busy, dev_act;
	logic [7:0]  rd_data;
	logic [22:0] maddr;
	mem_src_t    msel;
	mem_src_t    cur_src = SRC_ARRAY;
	int          w_cnt = 0, w_need = 40, drove = 0, bad_src = 0;
	int          fails = 0, checks_done = 0, cycles = 0;
	logic [7:0]  got[$];
	row_t        rows [9] = '{
		'{8'hD4, 24'hFF_FE0E, 16'h0004, 1'b0, 1'b0, 8'hA9},
		'{8'hD1, 24'hFF_FDFE, 16'h0003, 1'b1, 1'b0, 8'h5B},
		'{8'hD6, 24'h00_0005, 16'h0002, 1'b0, 1'b0, 8'h5F},
		'{8'hD3, 24'h00_01FF, 16'h0002, 1'b1, 1'b0, 8'hA5},
		'{8'h3B, 24'h7F_FE0E, 16'h0004, 1'b0, 1'b0, 8'hCD},
		'{8'h3B, 24'h3F_FFFE, 16'h0003, 1'b1, 1'b0, 8'h3C},
		'{8'h6B, 24'h00_160E, 16'h0004, 1'b0, 1'b1, 8'h24},
		'{8'h6B, 24'h3F_FFFF, 16'h0002, 1'b1, 1'b1, 8'h3D},
		'{8'h6B, 24'h00_0100, 16'h0001, 1'b0, 1'b0, 8'hFF}};

	flash_link_if flash_link_if_inst ();
	flash_read_dev flash_read_dev_inst (.mclk_i(mclk_i), .rst_i(rst_i),
		.ce_i(ce), .page_512_i(p512), .four_lane_en_i(quad_en),
		.mem_sel_o(msel), .mem_addr_o(maddr), .mem_data_i(mdata),
		.active_o(dev_act), .link(flash_link_if_inst));
	flash_read_host #(.SCK_HALF(6), .DEPTH(2)) flash_read_host_inst (
		.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .cmd_valid_i(valid),
		.cmd_ready_o(cmd_rdy), .cmd_op_i(op), .cmd_addr_i(addr),
		.cmd_len_i(len), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
		.rd_ready_i(rdy), .busy_o(busy), .link(flash_link_if_inst));
	flash_link_sva flash_link_sva_inst (.mclk_i(mclk_i), .rst_i(rst_i),
		.cs_n(flash_link_if_inst.cs_n), .sck(flash_link_if_inst.sck),
		.host_io(flash_link_if_inst.host_io),
		.host_oe_n(flash_link_if_inst.host_oe_n),
		.dev_io(flash_link_if_inst.dev_io),
		.dev_oe_n(flash_link_if_inst.dev_oe_n),
		.io(flash_link_if_inst.io));

	// ----
	// Models and monitors
	// ----
	function automatic logic [7:0] pat(input mem_src_t s,
		input logic [22:0] a);
		return a[7:0] ^ {a[15:9], a[22]} ^
			(s == SRC_BUF1 ? 8'hA5 : s == SRC_BUF2 ? 8'h5A : 8'h3C);
	endfunction : pat

	function automatic mem_src_t src_of(input logic [7:0] o);
		if (o == `OP_BUF1_FAST || o == `OP_BUF1_SLOW)
			return SRC_BUF1;
		if (o == `OP_BUF2_FAST || o == `OP_BUF2_SLOW)
			return SRC_BUF2;
		return SRC_ARRAY;
	endfunction : src_of

	// A four-lane read that is not honoured leaves the pulled-up lanes.
	function automatic logic [7:0] exp_byte(input row_t r, input int k);
		int          i;
		logic [22:0] a;
		i = r.addr[9:0] + k;
		if (r.op == `OP_QUAD_READ && !r.quad_en)
			return 8'hFF;
		if (src_of(r.op) != SRC_ARRAY)
			a = r.p512 ? 23'((r.addr[8:0] + k) % 512) : 23'(i % 528);
		else if (r.p512)
			a = 23'((r.addr[21:0] + k) % 4194304);
		else
			a = {13'(r.addr[22:10] + i / 528), 10'(i % 528)};
		return pat(src_of(r.op), a);
	endfunction : exp_byte

	always #2 mclk_i = ~mclk_i;
	always @(negedge mclk_i) mdata <= pat(msel, maddr);

	always @(posedge mclk_i) begin
		sck_q <= flash_link_if_inst.sck;
		if (flash_link_if_inst.cs_n)
			w_cnt <= 0;
		else if (flash_link_if_inst.sck && !sck_q) begin
			w_cnt <= w_cnt + 1;
			if (w_cnt < 8)
				w_op <= {w_op[6:0], flash_link_if_inst.io[0]};
			if (w_cnt == w_need)
				w_first <= flash_link_if_inst.io;
		end
		if (flash_link_if_inst.dev_oe_n != 4'hF) begin
			drove++;
			if (msel !== cur_src)
				bad_src++;
		end
		if (rd_valid && rdy)
			got.push_back(rd_data);
		cycles++;
		if (cycles == 60000) begin
			fails++;
			$display("Error run_time expected done seen hung");
			wrap_up();
		end
	end

	// ----
	// Tasks and sequence
	// ----
	task automatic cmp8(input string w, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", w, e, g);
		end
	endtask : cmp8

	task automatic cmp1(input string w, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %b seen %b", w, e, g);
		end
	endtask : cmp1

	task automatic check_idle();
		cmp1("cs_n", 1'b1, flash_link_if_inst.cs_n);
		cmp1("sck", 1'b0, flash_link_if_inst.sck);
		cmp1("cmd_ready", 1'b1, cmd_rdy);
		cmp1("busy", 1'b0, busy);
		cmp1("rd_valid", 1'b0, rd_valid);
		cmp1("active", 1'b0, dev_act);
		cmp8("dev_oe_n", 8'h0F,
			{4'h0, flash_link_if_inst.dev_oe_n});
		cmp8("host_oe_n", 8'h0F,
			{4'h0, flash_link_if_inst.host_oe_n});
	endtask : check_idle

	task automatic send(input logic [7:0] o, input logic [23:0] a,
		input logic [15:0] l);
		op = o;
		addr = a;
		len = l;
		valid = 1'b1;
		@(negedge mclk_i);
		valid = 1'b0;
	endtask : send

	task automatic run_row(input row_t r, input logic stall);
		int         n;
		logic [7:0] b;
		logic [3:0] m, e;
		got.delete();
		drove = 0;
		bad_src = 0;
		cur_src = src_of(r.op);
		w_need = (r.op == `OP_BUF1_SLOW || r.op == `OP_BUF2_SLOW) ? 32 : 40;
		p512 = r.p512;
		quad_en = r.quad_en;
		rdy = !stall;
		send(r.op, r.addr, r.len);
		if (stall) begin
			repeat (1200) @(negedge mclk_i);
			cmp1("held_full", 1'b1, rd_valid);
			cmp1("ready_busy", 1'b0, cmd_rdy);
			cmp1("active_stall", 1'b1, dev_act);
			ce = 1'b0;
			repeat (50) @(negedge mclk_i);
			ce = 1'b1;
			rdy = 1'b1;
		end
		n = 0;
		while ((busy !== 1'b0 || got.size() < r.len) && n < 20000) begin
			@(negedge mclk_i);
			n++;
		end
		cmp1("row_finished", 1'b1, n < 20000);
		cmp8("first_byte", r.first, got[0]);
		b = exp_byte(r, 0);
		m = r.op == `OP_QUAD_READ ? 4'hF : r.op == `OP_DUAL_READ ? 4'h3 : 4'h2;
		e = m == 4'hF ? b[7:4] : {2'b00, b[7], b[6] & m[0]};
		cmp8("byte_count", 8'(r.len), 8'(got.size()));
		for (int k = 0; k < r.len; k++)
			cmp8("rd_data", exp_byte(r, k), got[k]);
		cmp8("wire_op", r.op, w_op);
		cmp8("first_lanes", {4'h0, e & m}, {4'h0, w_first & m});
		cmp1("lanes_used", !(r.op == `OP_QUAD_READ && !r.quad_en),
			drove != 0);
		cmp1("source_kept", 1'b1, bad_src == 0);
	endtask : run_row

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (5) @(negedge mclk_i);
		rst_i = 1'b0;
		check_idle();
		$display("reset test done");
		foreach (rows[i]) begin
			run_row(rows[i], 1'b0);
			$display("row %0d done", i);
		end
		run_row('{8'hD4, 24'h00_020C, 16'h0006, 1'b0, 1'b0, 8'hAB},
			1'b1);
		$display("stall test done");
		quad_en = 1'b1;
		p512 = 1'b0;
		send(8'h6B, 24'h00_0000, 16'h0032);
		repeat (800) @(negedge mclk_i);
		rst_i = 1'b1;
		repeat (3) @(negedge mclk_i);
		rst_i = 1'b0;
		@(negedge mclk_i);
		check_idle();
		run_row(rows[4], 1'b0);
		$display("mid-run reset test done");
		wrap_up();
	end
endmodule : serial_flash_buffer_and_multi_lane_read_tb
